// file: hw/gpt_pkg.sv
// gated period timer: register map, field layout, reset values and enumerations
// assumes a 32-bit apb slave with one aligned word per register, index times four
package gpt_pkg;

	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 12;

	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h100;
	localparam logic [ADDR_W-1:0] IDX_PERIOD = 12'h102;
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h104;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h106;
	localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 12'h107;
	localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 12'h108;
	localparam int ADDR_LSB = 2;
	localparam int PADDR_W = ADDR_W + ADDR_LSB;

	// timer_control fields
	localparam int CTL_TIMER_ON = 15;
	localparam int CTL_STOP_IN_IDLE = 13;
	localparam int CTL_GATE_ACC_EN = 6;
	localparam int CTL_PRESCALE_MSB = 5;
	localparam int CTL_PRESCALE_LSB = 4;
	localparam int CTL_EXT_CLK_SYNC = 2;
	localparam int CTL_CLK_SRC_SEL = 1;
	localparam logic [CNT_W-1:0] CTL_WRITE_MASK = 16'hA076;

	// reset values and the count wrap value
	localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
	localparam logic [CNT_W-1:0] RST_PERIOD = 16'hFFFF;
	localparam logic [CNT_W-1:0] RST_CONTROL = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_WRAP = 16'h0000;

	// interrupt status, clear and enable share this layout
	localparam int IRQ_W = 2;
	localparam int IRQ_PERIOD_MATCH = 0;
	localparam int IRQ_GATE_END = 1;
	localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

	// prescaler: last count of each ratio 1:1, 1:8, 1:64, 1:256
	localparam int PS_W = 8;
	localparam logic [1:0] PS_SEL_1 = 2'h0;
	localparam logic [1:0] PS_SEL_8 = 2'h1;
	localparam logic [1:0] PS_SEL_64 = 2'h2;
	localparam logic [1:0] PS_SEL_256 = 2'h3;
	localparam logic [PS_W-1:0] PS_LAST_1 = 8'h00;
	localparam logic [PS_W-1:0] PS_LAST_8 = 8'h07;
	localparam logic [PS_W-1:0] PS_LAST_64 = 8'h3F;
	localparam logic [PS_W-1:0] PS_LAST_256 = 8'hFF;

	// apb slave phase, one-hot
	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_DONE = 2'b10
	} gpt_apb_e;

endpackage : gpt_pkg

// file: hw/gpt_sync2.sv
// two flip-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk
`timescale 1ns/100ps
module gpt_sync2 (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// level
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} gpt_sync_s;

	gpt_sync_s st;
	gpt_sync_s next_st;

	// stage1 feeds stage2 only
	always_comb begin
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;

endmodule : gpt_sync2

// file: hw/gpt_prescaler.sv
// four-step prescaler for the timer input ticks; output tick is registered
// assumes tick_in and clear come from logic on the same clock
`timescale 1ns/100ps
module gpt_prescaler
	import gpt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic clear,
	input wire logic [1:0] ratio_sel,
	// ticks
	input wire logic tick_in,
	output logic tick_out
);
	typedef struct packed {
		logic [PS_W-1:0] cnt;
		logic out;
	} gpt_ps_s;

	gpt_ps_s st;
	gpt_ps_s next_st;

	function automatic logic [PS_W-1:0] last_count(input logic [1:0] sel);
		case (sel)
			PS_SEL_1: last_count = PS_LAST_1;
			PS_SEL_8: last_count = PS_LAST_8;
			PS_SEL_64: last_count = PS_LAST_64;
			default: last_count = PS_LAST_256;
		endcase
	endfunction : last_count

	always_comb begin
		next_st = st;
		next_st.out = 1'b0;
		if (clear) begin
			next_st.cnt = '0;
		end else if (tick_in) begin
			if (st.cnt >= last_count(ratio_sel)) begin
				next_st.cnt = '0;
				next_st.out = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.out;

endmodule : gpt_prescaler

// file: hw/gpt_timer.sv
// 16-bit gated period timer with apb register access and a level interrupt
// assumes sys_clk is the instruction clock, cpu_idle and cpu_sleep come from logic on sys_clk,
// and the external clock or gate pin is asynchronous to sys_clk
`timescale 1ns/100ps
module gpt_timer
	import gpt_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpt_pkg::PADDR_W-1:0] paddr,
	input wire logic [gpt_pkg::DATA_W-1:0] pwdata,
	output logic [gpt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor power state
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	// external clock or gate pin
	input wire logic external_clock_gate_pin,
	// interrupt
	output logic irq
);
	import gpt_pkg::*;

	typedef struct packed {
		gpt_apb_e apb_state;
		logic [DATA_W-1:0] rdata;
		logic slverr;
		logic [CNT_W-1:0] count_register;
		logic [CNT_W-1:0] period_register;
		logic [CNT_W-1:0] timer_control;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
		logic irq_out;
		logic pin_d1;
		logic pin_d2;
	} gpt_timer_s;

	gpt_timer_s st;
	gpt_timer_s next_st;

	logic pin_sync;
	logic ps_tick_in;
	logic ps_clear;
	logic ps_tick;

	// control fields
	logic timer_on;
	logic stop_in_idle;
	logic gate_accumulate_enable;
	logic [1:0] prescale_select;
	logic ext_clock_sync;
	logic clock_source_select;

	// derived conditions
	logic gate_mode;
	logic async_mode;
	logic run_allowed;
	logic rise_raw;
	logic rise_synced;
	logic gate_fall;
	logic raw_tick;

	// bus decode
	logic access;
	logic wr_done;
	logic [ADDR_W-1:0] idx;
	logic count_wr;
	logic control_wr;
	logic ton_clear_wr;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] i);
		case (i)
			IDX_COUNT, IDX_PERIOD, IDX_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction : reg_mapped

	function automatic logic reg_hit(input logic [ADDR_W-1:0] i, input logic [ADDR_W-1:0] target);
		reg_hit = (i == target);
	endfunction : reg_hit

	gpt_sync2 u_pin_sync (
		.clk(sys_clk),
		.rst(rst),
		.async_in(external_clock_gate_pin),
		.sync_out(pin_sync)
	);

	gpt_prescaler u_prescaler (
		.clk(sys_clk),
		.rst(rst),
		.clear(ps_clear),
		.ratio_sel(prescale_select),
		.tick_in(ps_tick_in),
		.tick_out(ps_tick)
	);

	assign timer_on = st.timer_control[CTL_TIMER_ON];
	assign stop_in_idle = st.timer_control[CTL_STOP_IN_IDLE];
	assign gate_accumulate_enable = st.timer_control[CTL_GATE_ACC_EN];
	assign prescale_select = st.timer_control[CTL_PRESCALE_MSB:CTL_PRESCALE_LSB];
	assign ext_clock_sync = st.timer_control[CTL_EXT_CLK_SYNC];
	assign clock_source_select = st.timer_control[CTL_CLK_SRC_SEL];

	// gate only applies with the internal source; tcs=1 ignores it
	assign gate_mode = gate_accumulate_enable & ~clock_source_select;
	assign async_mode = clock_source_select & ~ext_clock_sync;

	// the pin always passes the two-flop synchroniser for metastability; the raw path
	// takes its edge straight from it, the synchronised path aligns one stage further
	assign rise_raw = pin_sync & ~st.pin_d1;
	assign rise_synced = st.pin_d1 & ~st.pin_d2;
	assign gate_fall = ~pin_sync & st.pin_d1;

	always_comb begin
		raw_tick = 1'b1;
		if (clock_source_select) begin
			if (ext_clock_sync) begin
				raw_tick = rise_synced;
			end else begin
				raw_tick = rise_raw;
			end
		end else if (gate_accumulate_enable) begin
			raw_tick = pin_sync;
		end
	end

	// idle halts every mode when stop_in_idle is set; sleep leaves only the async counter
	always_comb begin
		run_allowed = timer_on;
		if (cpu_idle && stop_in_idle) begin
			run_allowed = 1'b0;
		end
		if (cpu_sleep && !async_mode) begin
			run_allowed = 1'b0;
		end
	end

	assign ps_tick_in = run_allowed & raw_tick;

	// apb decode; a write lands at the edge where pready is seen high
	assign idx = paddr[PADDR_W-1:ADDR_LSB];
	assign access = psel & penable;
	assign wr_done = access & pwrite & (st.apb_state == APB_DONE);
	assign count_wr = wr_done & reg_hit(idx, IDX_COUNT);
	assign control_wr = wr_done & reg_hit(idx, IDX_CONTROL);
	assign ton_clear_wr = control_wr & timer_on & ~pwdata[CTL_TIMER_ON];

	// a count write clears the prescaler only while timer_on is set
	assign ps_clear = (count_wr & timer_on) | ton_clear_wr;

	always_comb begin
		irq_set = '0;
		irq_clr = '0;
		if (timer_on && ps_tick && (st.count_register == st.period_register)) begin
			irq_set[IRQ_PERIOD_MATCH] = 1'b1;
		end
		if (timer_on && gate_mode && gate_fall) begin
			irq_set[IRQ_GATE_END] = 1'b1;
		end
		if (wr_done && reg_hit(idx, IDX_IRQ_CLEAR)) begin
			irq_clr = pwdata[IRQ_W-1:0];
		end
	end

	always_comb begin
		next_st = st;
		next_st.pin_d1 = pin_sync;
		next_st.pin_d2 = st.pin_d1;

		// counting; a software write below overrides a tick in the same cycle
		if (timer_on && ps_tick) begin
			if (st.count_register == st.period_register) begin
				next_st.count_register = COUNT_WRAP;
			end else begin
				next_st.count_register = st.count_register + 16'h0001;
			end
		end

		// set wins over clear so an event in the clearing cycle is kept
		next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;

		case (st.apb_state)
			APB_IDLE: begin
				if (access) begin
					next_st.apb_state = APB_DONE;
					next_st.slverr = ~reg_mapped(idx);
					next_st.rdata = '0;
					case (idx)
						IDX_COUNT: next_st.rdata[CNT_W-1:0] = st.count_register;
						IDX_PERIOD: next_st.rdata[CNT_W-1:0] = st.period_register;
						IDX_CONTROL: next_st.rdata[CNT_W-1:0] = st.timer_control;
						IDX_IRQ_STATUS: next_st.rdata[IRQ_W-1:0] = st.irq_status;
						IDX_IRQ_ENABLE: next_st.rdata[IRQ_W-1:0] = st.irq_enable;
						default: next_st.rdata = '0;
					endcase
					if (pwrite) begin
						next_st.rdata = '0;
					end
				end
			end
			APB_DONE: begin
				next_st.apb_state = APB_IDLE;
				next_st.slverr = 1'b0;
				if (wr_done) begin
					case (idx)
						IDX_COUNT: next_st.count_register = pwdata[CNT_W-1:0];
						IDX_PERIOD: next_st.period_register = pwdata[CNT_W-1:0];
						IDX_CONTROL: next_st.timer_control = pwdata[CNT_W-1:0] & CTL_WRITE_MASK;
						IDX_IRQ_ENABLE: next_st.irq_enable = pwdata[IRQ_W-1:0];
						default: next_st.irq_enable = st.irq_enable;
					endcase
				end
			end
			default: begin
				next_st.apb_state = APB_IDLE;
				next_st.slverr = 1'b0;
			end
		endcase

		// level request for any enabled flag
		next_st.irq_out = |(next_st.irq_status & next_st.irq_enable);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st.apb_state <= APB_IDLE;
			st.rdata <= '0;
			st.slverr <= 1'b0;
			st.count_register <= RST_COUNT;
			st.period_register <= RST_PERIOD;
			st.timer_control <= RST_CONTROL;
			st.irq_status <= RST_IRQ;
			st.irq_enable <= RST_IRQ;
			st.irq_out <= 1'b0;
			st.pin_d1 <= 1'b0;
			st.pin_d2 <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = st.apb_state[1];
	assign pslverr = st.slverr;
	assign irq = st.irq_out;

endmodule : gpt_timer

// file: verif/gpt_pin_src.sv
// far-side source for the external clock or gate pin of the timer
// assumes the bench calls one task at a time; timing is unrelated to sys_clk
`timescale 1ns/100ps
module gpt_pin_src (
	// pin
	output logic pin
);
	// the pin rests low between bursts so that no stray edge is counted
	initial pin = 1'h0;
	task automatic burst(input int n, input int half_ns);
		for (int i = 0; i < n; i++) begin
			#(half_ns) pin = 1'h1;
			#(half_ns) pin = 1'h0;
		end
	endtask : burst
	// small offset keeps the gate change off the clock edge
	task automatic hold(input logic v);
		#7 pin = v;
	endtask : hold
endmodule : gpt_pin_src

// file: verif/gpt_timer_monitor.sv
// checker for apb timing, register readback and interrupt gating of the timer
// assumes it is bound to gpt_timer and sees its ports only
`timescale 1ns/100ps
module gpt_timer_chk
	import gpt_pkg::*;
(
	// clock, reset and apb
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpt_pkg::PADDR_W-1:0] paddr,
	input wire logic [gpt_pkg::DATA_W-1:0] pwdata,
	input wire logic [gpt_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt
	input wire logic irq
);
	logic [ADDR_W-1:0] idx;
	logic rd, wr, bad;
	logic [IRQ_W-1:0] en_sh;
	logic [CNT_W-1:0] ctl_sh;
	assign idx = paddr[PADDR_W-1:ADDR_LSB];
	assign rd = psel && penable && pready && !pwrite;
	assign wr = psel && penable && pready && pwrite;
	assign bad = !(idx inside {IDX_COUNT, IDX_PERIOD, IDX_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE});
	// shadows copy completed writes so readback and gating can be judged
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_sh <= RST_IRQ;
			ctl_sh <= RST_CONTROL;
		end else if (wr && idx == IDX_IRQ_ENABLE) begin
			en_sh <= pwdata[IRQ_W-1:0];
		end else if (wr && idx == IDX_CONTROL) begin
			ctl_sh <= pwdata[CNT_W-1:0] & CTL_WRITE_MASK;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == bad)
		else $error("pslverr does not match address map");
	a_err_zero: assert property (rd && pslverr |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_clr_zero: assert property (rd && idx == IDX_IRQ_CLEAR |-> prdata == 32'h0000_0000)
		else $error("clear register read not zero");
	a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_ctl_back: assert property (rd && idx == IDX_CONTROL |-> prdata == {16'h0000, ctl_sh})
		else $error("control readback wrong");
	a_irq_gate: assert property (irq |-> |(en_sh | $past(en_sh)))
		else $error("irq high with no enable set");
endmodule : gpt_timer_chk
bind gpt_timer gpt_timer_chk u_gpt_timer_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// file: verif/testbench.sv
// self-checking bench for the gated period timer: registers, modes, prescaler, idle, sleep, interrupts
// assumes the pin source model and the bound checker are compiled beside it
`timescale 1ns/100ps
module testbench;
	import gpt_pkg::*;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, cpu_idle, cpu_sleep, pin, irq, rde;
	logic [PADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdq;
	int error_cnt, n_checks, cyc_cnt;
	gpt_timer u_gpt_timer (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .external_clock_gate_pin(pin), .irq(irq));
	gpt_pin_src u_gpt_pin_src (.pin(pin));
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [DATA_W-1:0] got, input int lo, input int hi);
		n_checks++;
		if (((got >= lo) && (got <= hi)) !== 1'h1) begin
			error_cnt++;
			$display("BAD %s expected %0d..%0d seen %0h", nm, lo, hi, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// one apb transfer; the trailing edge keeps the next setup off this one's release
	// pready and read data are taken mid-cycle, so the edge that completes the transfer is the one after
	task automatic ap(input logic w, input logic [ADDR_W-1:0] ix, input logic [15:0] d);
		int k;
		logic rdy;
		k = 0;
		rdy = 1'h0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {ix, 2'h0};
		pwdata <= {16'h0000, d};
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(negedge sys_clk);
			rdy = pready;
			rdq = prdata;
			rde = pslverr;
			@(posedge sys_clk);
			k++;
		end while (rdy !== 1'h1 && k < 40);
		if (rdy !== 1'h1) error_cnt++;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask : ap
	task automatic wirq(input int n);
		for (int k = 0; k < n && irq !== 1'h1; k++) cyc(1);
		cyc(1);
	endtask : wirq
	task automatic t_regs;
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("count rst", rdq, 0, 0);
		ap(1'h0, IDX_PERIOD, 16'h0000);
		chk("period rst", rdq, 16'hFFFF, 16'hFFFF);
		ap(1'h1, IDX_CONTROL, 16'hFFFF);
		ap(1'h0, IDX_CONTROL, 16'h0000);
		chk("control mask", rdq, 16'hA076, 16'hA076);
		ap(1'h1, IDX_CONTROL, 16'h0000);
		ap(1'h0, 12'h0FF, 16'h0000);
		chk("unmapped err", rde, 1, 1);
		ap(1'h1, IDX_IRQ_STATUS, 16'h0003);
		ap(1'h0, IDX_IRQ_CLEAR, 16'h0000);
		ap(1'h0, IDX_IRQ_STATUS, 16'h0000);
		chk("status ro", rdq, 0, 0);
	endtask : t_regs
	task automatic t_timer;
		ap(1'h1, IDX_PERIOD, 16'h0005);
		ap(1'h1, IDX_COUNT, 16'h0000);
		ap(1'h1, IDX_IRQ_ENABLE, 16'h0001);
		ap(1'h1, IDX_CONTROL, 16'h8000);
		wirq(30);
		chk("irq match", irq, 1, 1);
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("count wrap", rdq, 0, 5);
		ap(1'h1, IDX_IRQ_ENABLE, 16'h0000);
		cyc(2);
		chk("irq masked", irq, 0, 0);
		ap(1'h1, IDX_CONTROL, 16'h0000);
		ap(1'h0, IDX_IRQ_STATUS, 16'h0000);
		chk("flag sticky", rdq[0], 1, 1);
		ap(1'h1, IDX_IRQ_CLEAR, 16'h0001);
		ap(1'h0, IDX_IRQ_STATUS, 16'h0000);
		chk("flag clear", rdq[0], 0, 0);
	endtask : t_timer
	task automatic t_presc;
		int sh[4] = '{0, 3, 6, 8};
		ap(1'h1, IDX_PERIOD, 16'hFFFF);
		for (int s = 0; s < 4; s++) begin
			ap(1'h1, IDX_COUNT, 16'h0000);
			ap(1'h1, IDX_CONTROL, {8'h80, 2'h0, s[1:0], 4'h0});
			cyc(512);
			ap(1'h1, IDX_CONTROL, 16'h0000);
			ap(1'h0, IDX_COUNT, 16'h0000);
			chk("prescaled", rdq, 508 >> sh[s], 524 >> sh[s]);
		end
	endtask : t_presc
	task automatic t_idle;
		ap(1'h1, IDX_COUNT, 16'h1234);
		ap(1'h1, IDX_CONTROL, 16'h0036);
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("count kept", rdq, 16'h1234, 16'h1234);
		ap(1'h1, IDX_COUNT, 16'h0000);
		cpu_idle <= 1'h1;
		ap(1'h1, IDX_CONTROL, 16'hA000);
		cyc(40);
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("idle halt", rdq, 0, 0);
		cpu_idle <= 1'h0;
		cyc(40);
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("idle resume", rdq, 38, 48);
		ap(1'h1, IDX_CONTROL, 16'h0000);
	endtask : t_idle
	task automatic t_ext;
		logic [15:0] cw[4] = '{16'h8006, 16'h8002, 16'h8006, 16'hA002};
		logic sl[4] = '{1'h0, 1'h1, 1'h1, 1'h0};
		int ex[4] = '{10, 10, 0, 0};
		for (int i = 0; i < 4; i++) begin
			ap(1'h1, IDX_COUNT, 16'h0000);
			cpu_sleep <= sl[i];
			cpu_idle <= (i == 3);
			ap(1'h1, IDX_CONTROL, cw[i]);
			u_gpt_pin_src.burst(10, 730);
			cyc(10);
			cpu_sleep <= 1'h0;
			cpu_idle <= 1'h0;
			ap(1'h1, IDX_CONTROL, 16'h0000);
			ap(1'h0, IDX_COUNT, 16'h0000);
			chk("ext count", rdq, ex[i], ex[i]);
		end
	endtask : t_ext
	task automatic t_gate;
		ap(1'h1, IDX_COUNT, 16'h0000);
		ap(1'h1, IDX_IRQ_ENABLE, 16'h0002);
		ap(1'h1, IDX_CONTROL, 16'h8040);
		cyc(5);
		u_gpt_pin_src.hold(1'h1);
		cyc(50);
		u_gpt_pin_src.hold(1'h0);
		wirq(20);
		chk("gate end irq", irq, 1, 1);
		ap(1'h1, IDX_CONTROL, 16'h0000);
		ap(1'h0, IDX_COUNT, 16'h0000);
		chk("gated count", rdq, 48, 52);
		ap(1'h0, IDX_IRQ_STATUS, 16'h0000);
		chk("gate flag", rdq[1], 1, 1);
	endtask : t_gate
	task automatic results;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 10000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		{sys_clk, psel, penable, pwrite, cpu_idle, cpu_sleep} = '0;
		{paddr, pwdata, error_cnt, n_checks, cyc_cnt} = '0;
		rst = 1'h1;
		cyc(4);
		rst <= 1'h0;
		cyc(1);
		t_regs();
		t_timer();
		t_presc();
		t_idle();
		t_ext();
		t_gate();
		results();
	end
endmodule : testbench
